// file: i2cs_pkg.sv
/*
 * constants, types and mode decoders for the two-wire slave engine.
 * assumes one 20 MHz clock; the bus lines arrive unsynchronised.
 */
package i2cs_pkg;

   localparam int          CLK_HZ        = 20_000_000;
   localparam int          FIFO_WIDTH    = 8;
   localparam int          FIFO_DEPTH    = 32;

   localparam logic [3:0]  MODE_SLV7     = 4'h6;
   localparam logic [3:0]  MODE_SLV10    = 4'h7;
   localparam logic [3:0]  MODE_FW_MST   = 4'hB;
   localparam logic [3:0]  MODE_SLV7_SP  = 4'hE;
   localparam logic [3:0]  MODE_SLV10_SP = 4'hF;

   localparam logic [7:0]  GC_ADDR       = 8'h00;
   localparam logic [4:0]  TEN_HDR       = 5'h1E;
   localparam logic [7:0]  OWN_ADDR_RST  = 8'h00;
   localparam logic [7:0]  BUF_RST       = 8'h00;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   localparam logic [3:0]  LAST_TX_FALL  = 4'h7;
   localparam logic [1:0]  PINS_INPUT    = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_ADDR    = 3'h1,
      ST_ADDR_AK = 3'h3,
      ST_RX      = 3'h2,
      ST_RX_AK   = 3'h6,
      ST_TX      = 3'h7,
      ST_TX_AK   = 3'h5
   } i2cs_state_e;

   typedef struct packed {
      logic stop_seen;
      logic start_seen;
      logic read_not_write;
      logic data_not_addr;
      logic update_address_flag;
      logic buffer_full_flag;
   } i2cs_status_s;

   function automatic logic i2cs_ten_bit(input logic [3:0] mode);
      return (mode == MODE_SLV10) || (mode == MODE_SLV10_SP);
   endfunction : i2cs_ten_bit

   function automatic logic i2cs_sp_irq(input logic [3:0] mode);
      return (mode == MODE_SLV7_SP) || (mode == MODE_SLV10_SP) || (mode == MODE_FW_MST);
   endfunction : i2cs_sp_irq

   function automatic logic i2cs_is_i2c(input logic [3:0] mode);
      return (mode == MODE_SLV7) || (mode == MODE_SLV10) || i2cs_sp_irq(mode);
   endfunction : i2cs_is_i2c

endpackage : i2cs_pkg

// file: i2cs_slave.sv
/*
 * two-wire slave engine with its receive-data fifo.
 * assumes scl/sda are open-drain lines resolved outside from the
 * enables; control and status bits are plain ports from software.
 */
`timescale 1ns/10ps

module i2cs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;

   assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
   assign out_valid = (wr_ptr_reg != rd_ptr_reg);
   assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule : i2cs_fifo

//Contract
// - on match or data byte, acknowledge and copy shift register to buffer.
// - buffer full or overflow set: no acknowledge, no copy, interrupt still set.
// - buffer read clears full flag; overflow stays until software clears it.
// - once enabled wait for start, shift eight bits on rising clock edges.
// - compare shift bits 7..1 with own address at eighth falling edge.
// - address match: load buffer, set full, acknowledge, interrupt at ninth fall.
// - 10-bit header is 11110, then address bits 9 and 8, then write.
// - each 10-bit write address byte sets update flag, holds clock until address rewrite.
// - 10-bit read after repeated start accepts header alone, sets interrupt, full.
// - matched write address clears direction bit and loads address into buffer.
// - interrupt set for every byte; only software clears it.
// - matched read sets direction, acknowledges, holds clock until release bit set.
// - transmitter shifts each data bit out on falling clock edges.
// - transmitter latches master acknowledge on ninth rising edge.
// - master not-acknowledge ends transfer, resets status, waits for next start.
// - with general call enabled, also match the all-zero write address.
// - general call loads buffer, sets full, interrupt at ninth falling edge.
// - 10-bit general call skips update flag and second address byte.
// - start-seen and stop-seen cleared by reset and when port disabled.
// - start, stop and byte events raise interrupt in the interrupt modes.
// - slave-transmitter drives its own data over the input pin state.
// - open-drain drive only when enabled, two-wire mode, pins set as inputs.
// - mode field offers 7-bit and 10-bit slave, with or without start/stop interrupts.
module i2cs_slave
   import i2cs_pkg::*;
#(
   parameter int FIFO_W = FIFO_WIDTH,
   parameter int FIFO_D = FIFO_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe_n,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic        port_enable_bit,
   input  wire logic [3:0]  port_mode_select,
   input  wire logic        general_call_enable,
   input  wire logic [1:0]  port_c_direction,
   input  wire logic        own_address_wr,
   input  wire logic [7:0]  own_address_wdata,
   input  wire logic        buffer_rd,
   input  wire logic        buffer_wr,
   input  wire logic [7:0]  buffer_wdata,
   input  wire logic        clock_release_set,
   input  wire logic        overflow_clear,
   input  wire logic        interrupt_clear,
   output logic [7:0]       rx_tx_buffer,
   output logic [7:0]       own_address_reg,
   output i2cs_status_s     port_status_reg,
   output logic             receive_overflow_flag,
   output logic             port_interrupt_flag,
   output logic             clock_release_bit,
   output logic [FIFO_W-1:0] rx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready
);
   logic [2:0]  scl_sync_reg;
   logic [2:0]  sda_sync_reg;
   i2cs_state_e state_reg;
   logic [3:0]  cnt_reg;
   logic [7:0]  serial_shift_reg;
   logic        ack_drive_reg;
   logic        to_tx_reg;
   logic        expect_low_reg;
   logic        ten_done_reg;
   logic        master_ack_reg;
   logic        fifo_in_ready;
   logic        scl_rise, scl_fall, start_det, stop_det;
   logic        ten, gc_hit, hdr_hit, addr_hit, byte_end, accept, take, refuse;
   logic        ninth_fall, tx_nack_end, read_req, ua_set, pins_ok;
   logic        scl_hold, sda_low;

   // stage 0 is only read by stage 1; edges come from stages 1 and 2
   always_ff @(posedge clk) begin
      if (reset) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      end
   end

   assign scl_rise  = scl_sync_reg[1] && !scl_sync_reg[2];
   assign scl_fall  = !scl_sync_reg[1] && scl_sync_reg[2];
   assign start_det = scl_sync_reg[1] && scl_sync_reg[2] &&
                      !sda_sync_reg[1] && sda_sync_reg[2];
   assign stop_det  = scl_sync_reg[1] && scl_sync_reg[2] &&
                      sda_sync_reg[1] && !sda_sync_reg[2];

   always_comb begin
      ten     = i2cs_ten_bit(port_mode_select);
      gc_hit  = general_call_enable && (serial_shift_reg == GC_ADDR);
      hdr_hit = (serial_shift_reg[7:3] == TEN_HDR) &&
                (serial_shift_reg[7:1] == own_address_reg[7:1]);
      if (expect_low_reg) begin
         addr_hit = (serial_shift_reg == own_address_reg);
      end else if (ten) begin
         // a read header counts only after a full 10-bit write match
         addr_hit = gc_hit || (hdr_hit && (!serial_shift_reg[0] || ten_done_reg));
      end else begin
         addr_hit = gc_hit || (serial_shift_reg[7:1] == own_address_reg[7:1]);
      end
   end

   assign byte_end    = scl_fall && (cnt_reg == BITS_PER_BYTE) &&
                        ((state_reg == ST_ADDR) || (state_reg == ST_RX));
   assign accept      = byte_end && ((state_reg == ST_RX) || addr_hit);
   assign take        = accept && !port_status_reg.buffer_full_flag &&
                        !receive_overflow_flag;
   assign refuse      = accept && (port_status_reg.buffer_full_flag ||
                        receive_overflow_flag);
   assign ninth_fall  = scl_fall && ((state_reg == ST_ADDR_AK) ||
                        (state_reg == ST_RX_AK) || (state_reg == ST_TX_AK));
   assign tx_nack_end = scl_fall && (state_reg == ST_TX_AK) && !master_ack_reg;
   assign read_req    = take && (state_reg == ST_ADDR) && !expect_low_reg &&
                        serial_shift_reg[0];
   assign ua_set      = take && (state_reg == ST_ADDR) && ten && !gc_hit &&
                        (expect_low_reg || !serial_shift_reg[0]);

   always_ff @(posedge clk) begin
      if (reset || !port_enable_bit) begin
         state_reg        <= ST_IDLE;
         cnt_reg          <= '0;
         serial_shift_reg <= BUF_RST;
         ack_drive_reg    <= 1'b0;
         to_tx_reg        <= 1'b0;
         expect_low_reg   <= 1'b0;
         ten_done_reg     <= 1'b0;
         master_ack_reg   <= 1'b0;
      end else if (stop_det) begin
         state_reg      <= ST_IDLE;
         ack_drive_reg  <= 1'b0;
         expect_low_reg <= 1'b0;
         ten_done_reg   <= 1'b0;
      end else if (start_det) begin
         state_reg     <= ST_ADDR;
         cnt_reg       <= '0;
         ack_drive_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_RX: begin
               if (scl_rise && (cnt_reg != BITS_PER_BYTE)) begin
                  serial_shift_reg <= {serial_shift_reg[6:0], sda_sync_reg[1]};
                  cnt_reg          <= cnt_reg + 4'h1;
               end
               if (byte_end) begin
                  if (accept) begin
                     state_reg     <= (state_reg == ST_ADDR) ? ST_ADDR_AK : ST_RX_AK;
                     ack_drive_reg <= take;
                     to_tx_reg     <= read_req;
                     if (state_reg == ST_ADDR) begin
                        expect_low_reg <= ua_set && !expect_low_reg;
                        ten_done_reg   <= ten_done_reg || (ua_set && expect_low_reg);
                     end
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_AK, ST_RX_AK: begin
               if (scl_fall) begin
                  ack_drive_reg <= 1'b0;
                  cnt_reg       <= '0;
                  if (!ack_drive_reg) begin
                     state_reg <= ST_IDLE;
                  end else if (to_tx_reg) begin
                     state_reg <= ST_TX;
                  end else if (expect_low_reg) begin
                     state_reg <= ST_ADDR;
                  end else begin
                     state_reg <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  serial_shift_reg <= {serial_shift_reg[6:0], 1'b1};
                  cnt_reg          <= cnt_reg + 4'h1;
                  if (cnt_reg == LAST_TX_FALL) begin
                     state_reg <= ST_TX_AK;
                  end
               end else if (buffer_wr) begin
                  serial_shift_reg <= buffer_wdata;
               end
            end
            ST_TX_AK: begin
               if (scl_rise) begin
                  master_ack_reg <= !sda_sync_reg[1];
               end
               if (scl_fall) begin
                  cnt_reg   <= '0;
                  state_reg <= master_ack_reg ? ST_TX : ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_tx_buffer <= BUF_RST;
      end else if (take) begin
         rx_tx_buffer <= serial_shift_reg;
      end else if (buffer_wr) begin
         rx_tx_buffer <= buffer_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         own_address_reg <= OWN_ADDR_RST;
      end else if (own_address_wr) begin
         own_address_reg <= own_address_wdata;
      end
   end

   // set wins over the software clear in every status, overflow and interrupt flag below
   always_ff @(posedge clk) begin
      if (reset || !port_enable_bit) begin
         port_status_reg.start_seen <= 1'b0;
         port_status_reg.stop_seen  <= 1'b0;
      end else if (start_det) begin
         port_status_reg.start_seen <= 1'b1;
         port_status_reg.stop_seen  <= 1'b0;
      end else if (stop_det) begin
         port_status_reg.start_seen <= 1'b0;
         port_status_reg.stop_seen  <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !port_enable_bit) begin
         port_status_reg.buffer_full_flag <= 1'b0;
      end else if (take) begin
         port_status_reg.buffer_full_flag <= 1'b1;
      end else if (buffer_rd || tx_nack_end) begin
         port_status_reg.buffer_full_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !port_enable_bit) begin
         port_status_reg.update_address_flag <= 1'b0;
      end else if (ua_set) begin
         port_status_reg.update_address_flag <= 1'b1;
      end else if (own_address_wr || tx_nack_end) begin
         port_status_reg.update_address_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !port_enable_bit || tx_nack_end) begin
         port_status_reg.read_not_write <= 1'b0;
         port_status_reg.data_not_addr  <= 1'b0;
      end else if (take) begin
         if (state_reg == ST_ADDR) begin
            port_status_reg.read_not_write <= read_req;
            port_status_reg.data_not_addr  <= 1'b0;
         end else begin
            port_status_reg.data_not_addr <= 1'b1;
         end
      end else if (ninth_fall && (state_reg == ST_TX_AK)) begin
         port_status_reg.data_not_addr <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !port_enable_bit) begin
         receive_overflow_flag <= 1'b0;
      end else if (refuse && port_status_reg.buffer_full_flag) begin
         receive_overflow_flag <= 1'b1;
      end else if (overflow_clear) begin
         receive_overflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         port_interrupt_flag <= 1'b0;
      end else if (ninth_fall || (port_enable_bit && i2cs_sp_irq(port_mode_select) &&
                   (start_det || stop_det))) begin
         port_interrupt_flag <= 1'b1;
      end else if (interrupt_clear) begin
         port_interrupt_flag <= 1'b0;
      end
   end

   // a software release in the same cycle as a hardware hold is kept
   always_ff @(posedge clk) begin
      if (reset) begin
         clock_release_bit <= 1'b1;
      end else if (clock_release_set) begin
         clock_release_bit <= 1'b1;
      end else if (read_req || (scl_fall && (state_reg == ST_TX_AK) && master_ack_reg)) begin
         clock_release_bit <= 1'b0;
      end
   end

   i2cs_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_rx_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_data   (serial_shift_reg),
      .in_valid  (take && (state_reg == ST_RX)),
      .in_ready  (fifo_in_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

   // a full fifo stretches the clock before the next data byte
   always_comb begin
      pins_ok  = port_enable_bit && i2cs_is_i2c(port_mode_select) &&
                 (port_c_direction == PINS_INPUT);
      scl_hold = (cnt_reg == '0) &&
                 ((port_status_reg.update_address_flag &&
                   ((state_reg == ST_ADDR) || (state_reg == ST_RX))) ||
                  ((state_reg == ST_TX) && !clock_release_bit) ||
                  ((state_reg == ST_RX) && !fifo_in_ready));
      sda_low  = (ack_drive_reg && ((state_reg == ST_ADDR_AK) || (state_reg == ST_RX_AK))) ||
                 ((state_reg == ST_TX) && !serial_shift_reg[7]);
   end

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         scl_oe_n <= !(pins_ok && scl_hold);
         sda_oe_n <= !(pins_ok && sda_low);
      end
   end

   ack_on_take_a: assert property (@(posedge clk) disable iff (reset)
      take |=> ack_drive_reg ##0 (rx_tx_buffer == $past(serial_shift_reg)))
      else $error("accepted byte not acknowledged or not buffered");

   refuse_nack_a: assert property (@(posedge clk) disable iff (reset)
      refuse |=> !ack_drive_reg && $stable(rx_tx_buffer))
      else $error("refused byte was acknowledged or buffered");

   overflow_hold_a: assert property (@(posedge clk) disable iff (reset)
      (receive_overflow_flag && port_enable_bit && !overflow_clear) |=> receive_overflow_flag)
      else $error("overflow flag dropped without software clear");

   read_clear_a: assert property (@(posedge clk) disable iff (reset)
      (buffer_rd && !take) |=> !port_status_reg.buffer_full_flag)
      else $error("buffer read did not clear full flag");

   ninth_irq_a: assert property (@(posedge clk) disable iff (reset)
      ninth_fall |=> port_interrupt_flag)
      else $error("no interrupt at ninth falling edge");

   ua_stretch_a: assert property (@(posedge clk) disable iff (reset)
      (pins_ok && port_status_reg.update_address_flag && (cnt_reg == '0) &&
       (state_reg == ST_RX)) |=> !scl_oe_n)
      else $error("clock not held while address update pending");

   read_dir_a: assert property (@(posedge clk) disable iff (reset)
      (read_req && !clock_release_set) |=> port_status_reg.read_not_write && !clock_release_bit)
      else $error("read request did not set direction and hold clock");

   nack_end_a: assert property (@(posedge clk) disable iff (reset)
      (tx_nack_end && port_enable_bit && !stop_det && !start_det) |=>
         (state_reg == ST_IDLE) && !port_status_reg.read_not_write)
      else $error("master nack did not end transmission");

   disable_clear_a: assert property (@(posedge clk) disable iff (reset)
      !port_enable_bit |=> !port_status_reg.start_seen && !port_status_reg.stop_seen)
      else $error("start or stop flag survived disable");

   start_addr_a: assert property (@(posedge clk) disable iff (reset)
      (start_det && port_enable_bit) |=> (state_reg == ST_ADDR) && (cnt_reg == '0))
      else $error("start did not begin address reception");

endmodule : i2cs_slave

// file: i2cs_bus_master.sv
/*
 * behavioural two-wire bus master: open-drain clock and data, 400 ns bits.
 * assumes the bench resolves both lines as wired-and with pull-ups.
 */
`timescale 1ns/10ps

module i2cs_bus_master (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_oe_n,
   output logic      sda_oe_n
);
   initial begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
   end

   // bounded, so a slave that never lets go cannot hang the model
   task automatic wait_high();
      int n;
      n = 0;
      while (scl !== 1'b1 && n < 20000) begin
         #10;
         n++;
      end
   endtask : wait_high

   task automatic bit_x(input logic b, output logic r);
      #100 sda_oe_n = b;
      #100 scl_oe_n = 1'b1;
      wait_high();
      #200 r = sda;
      scl_oe_n = 1'b0;
   endtask : bit_x

   task automatic start();
      #100 sda_oe_n = 1'b1;
      #100 scl_oe_n = 1'b1;
      wait_high();
      #200 sda_oe_n = 1'b0;
      #200 scl_oe_n = 1'b0;
   endtask : start

   task automatic stop();
      #100 sda_oe_n = 1'b0;
      #100 scl_oe_n = 1'b1;
      wait_high();
      #200 sda_oe_n = 1'b1;
      #200;
   endtask : stop

   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                       output logic ak);
      logic t;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], t);
         r[i] = t;
      end
      bit_x(a, ak);
   endtask : xfer
endmodule : i2cs_bus_master

// file: i2c_slave_address_transfer_tb.sv
/*
 * self-checking bench of the two-wire slave with a bus master model.
 * assumes 20 MHz clock, pull-ups on both lines, strobes as one-cycle pulses.
 */
`timescale 1ns/10ps

module i2c_slave_address_transfer_tb;
   import i2cs_pkg::*;
   logic         clk, reset, en, gce, ak, ovf, irq, crel, rx_valid;
   logic         scl_oe_n, sda_oe_n, m_scl_oe_n, m_sda_oe_n;
   logic [6:0]   stb;
   logic [3:0]   mode;
   logic [1:0]   dir;
   logic [7:0]   wdata, lfsr, r8, buf_q, rx_data;
   i2cs_status_s st;
   int           n_mismatch, n_tests;
   logic [7:0]   exp_q[$];
   wire          scl = scl_oe_n & m_scl_oe_n;
   wire          sda = sda_oe_n & m_sda_oe_n;

   i2cs_slave u_dut (.clk(clk), .reset(reset), .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n),
      .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n), .port_enable_bit(en),
      .port_mode_select(mode), .general_call_enable(gce), .port_c_direction(dir),
      .own_address_wr(stb[6]), .own_address_wdata(wdata), .buffer_rd(stb[5]),
      .buffer_wr(stb[4]), .buffer_wdata(wdata), .clock_release_set(stb[3]),
      .overflow_clear(stb[2]), .interrupt_clear(stb[1]), .rx_tx_buffer(buf_q),
      .own_address_reg(), .port_status_reg(st), .receive_overflow_flag(ovf),
      .port_interrupt_flag(irq), .clock_release_bit(crel), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(stb[0]));
   i2cs_bus_master u_mst (.scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));

   always #25 clk = ~clk;

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // {rw, update, full, overflow, interrupt}
   function automatic logic [7:0] fl();
      return {3'h0, st.read_not_write, st.update_address_flag, st.buffer_full_flag, ovf, irq};
   endfunction : fl

   task automatic sw(input int k, input logic [7:0] v);
      @(posedge clk) #1 stb[k] = 1'b1;
      wdata = v;
      @(posedge clk) #1 stb = 7'h00;
   endtask : sw

   task automatic xw(input logic [7:0] d, input logic eak, input logic [7:0] ef);
      u_mst.xfer(d, 1'b1, r8, ak);
      repeat (10) @(posedge clk);
      chk({7'h00, ak}, {7'h00, eak});
      chk(fl(), ef);
   endtask : xw

   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nxt

   initial begin
      #300000;
      n_mismatch++;
      test_done();
   end

   initial begin
      {clk, en, gce, stb, wdata} = '0;
      mode = MODE_SLV7;
      dir = 2'h3;
      reset = 1'b1;
      lfsr = 8'h2D;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      chk({st, ovf, irq}, 8'h00);
      chk({7'h00, crel}, 8'h01);
      en = 1'b1;
      sw(6, 8'hA4);
      u_mst.start();
      xw(8'hA4, 1'b0, 8'h05);
      chk(buf_q, 8'hA4);
      sw(5, 8'h00);
      sw(1, 8'h00);
      chk(fl(), 8'h00);
      lfsr = nxt(lfsr);
      exp_q.push_back(lfsr);
      xw(lfsr, 1'b0, 8'h05);
      sw(1, 8'h00);
      xw(8'h77, 1'b1, 8'h07);
      chk(buf_q, lfsr);
      sw(5, 8'h00);
      chk(fl(), 8'h03);
      sw(2, 8'h00);
      sw(1, 8'h00);
      u_mst.stop();
      repeat (6) @(posedge clk);
      chk({7'h00, st.stop_seen}, 8'h01);
      $display("write and overflow test done");
      u_mst.start();
      xw(8'h42, 1'b1, 8'h00);
      u_mst.stop();
      // pins not both inputs: byte still taken, but no drive on the line
      @(posedge clk) #1 dir = 2'h1;
      u_mst.start();
      xw(8'hA4, 1'b1, 8'h05);
      sw(5, 8'h00);
      sw(1, 8'h00);
      u_mst.stop();
      @(posedge clk) #1 dir = 2'h3;
      gce = 1'b1;
      u_mst.start();
      xw(8'h00, 1'b0, 8'h05);
      chk(buf_q, 8'h00);
      sw(5, 8'h00);
      sw(1, 8'h00);
      u_mst.stop();
      gce = 1'b0;
      $display("address match tests done");
      u_mst.start();
      xw(8'hA5, 1'b0, 8'h15);
      chk({7'h00, crel}, 8'h00);
      sw(5, 8'h00);
      sw(1, 8'h00);
      lfsr = nxt(lfsr);
      fork
         u_mst.xfer(8'hFF, 1'b1, r8, ak);
         begin
            repeat (40) @(posedge clk);
            chk({7'h00, scl_oe_n}, 8'h00);
            sw(4, lfsr);
            sw(3, 8'h00);
         end
      join
      repeat (10) @(posedge clk);
      chk(r8, lfsr);
      chk(fl(), 8'h01);
      u_mst.stop();
      $display("transmit test done");
      sw(6, 8'hF2);
      mode = MODE_SLV10;
      u_mst.start();
      xw(8'hF2, 1'b0, 8'h0D);
      chk({7'h00, scl_oe_n}, 8'h00);
      sw(6, 8'h3C);
      sw(5, 8'h00);
      sw(1, 8'h00);
      xw(8'h3C, 1'b0, 8'h0D);
      chk(buf_q, 8'h3C);
      sw(6, 8'hF2);
      sw(5, 8'h00);
      sw(1, 8'h00);
      u_mst.start();
      chk({7'h00, st.start_seen}, 8'h01);
      xw(8'hF3, 1'b0, 8'h15);
      chk(buf_q, 8'hF3);
      sw(3, 8'h00);
      sw(5, 8'h00);
      sw(1, 8'h00);
      u_mst.stop();
      $display("ten-bit address test done");
      chk({7'h00, rx_valid}, 8'h01);
      chk(rx_data, exp_q.pop_front());
      sw(0, 8'h00);
      chk({7'h00, rx_valid}, 8'h00);
      $display("receive queue test done");
      test_done();
   end
endmodule : i2c_slave_address_transfer_tb
